// >>> pkg/hcl_pkg.sv
package hcl_pkg;

  // Control port offsets (relative to control_port_base)
  localparam logic [2:0] LOADER_COMMAND_PORT_OFS = 3'h5;
  localparam logic [2:0] DOWNLOAD_END_PORT_OFS   = 3'h6;

  // Loader command bytes
  localparam logic [7:0] CMD_JUMP_ROM   = 8'h57;
  localparam logic [7:0] CMD_DOWNLOAD   = 8'hAA;
  localparam logic [7:0] CMD_REAPPLY    = 8'h5A;
  localparam logic [7:0] CMD_END        = 8'h00;
  localparam logic [7:0] START_ADDR_LO  = 8'h00;
  localparam logic [7:0] START_ADDR_HI  = 8'h40;

  // Hostload image: byte 0 of the stored table is image byte 5
  localparam int         CFG_BYTES      = 19;
  localparam int         CFG_IDX_W      = 5;
  localparam logic [4:0] CFG_LAST       = 5'h12;
  localparam logic [4:0] IDX_ALT_CD     = 5'h00;
  localparam logic [4:0] IDX_MISC       = 5'h02;
  localparam logic [4:0] IDX_GLOBAL     = 5'h03;
  localparam logic [4:0] IDX_CODE_BASE  = 5'h04;
  localparam logic [4:0] IDX_FM_LEVEL   = 5'h05;
  localparam logic [4:0] IDX_MONO_DSP   = 5'h09;
  localparam logic [4:0] IDX_CHECKSUM   = 5'h0A;
  localparam logic [4:0] IDX_GLOBAL2    = 5'h0B;
  localparam logic [4:0] IDX_CD_LEN     = 5'h0C;
  localparam logic [4:0] IDX_IRQ_AB     = 5'h0E;
  localparam logic [4:0] IDX_IRQ_CD     = 5'h0F;
  localparam logic [4:0] IDX_IRQ_EF     = 5'h10;
  localparam logic [4:0] IDX_DMA_AB     = 5'h11;
  localparam logic [4:0] IDX_DMA_C_IRQG = 5'h12;

  // Writable bit masks per byte; reserved positions are dropped
  localparam logic [7:0] MASK_ALT_CD    = 8'h07;
  localparam logic [7:0] MASK_MISC      = 8'hFF;
  localparam logic [7:0] MASK_GLOBAL    = 8'hEC;
  localparam logic [7:0] MASK_FM_LEVEL  = 8'h70;
  localparam logic [7:0] MASK_MONO_DSP  = 8'h8F;
  localparam logic [7:0] MASK_GLOBAL2   = 8'h1F;
  localparam logic [7:0] MASK_ALL       = 8'hFF;

  // Code base expected per load method (arbitrary neutral values)
  localparam logic [7:0] CODE_BASE_EEPROM = 8'hE1;
  localparam logic [7:0] CODE_BASE_HOST   = 8'hE2;

  // Field positions
  localparam int MISC_IRQ_POL   = 7;
  localparam int MISC_PNP_BLK   = 5;
  localparam int MISC_FIRST_BLK = 4;
  localparam int MISC_SECOND_BLK = 3;
  localparam int MISC_HW_VOL    = 2;
  localparam int GLB_FM_EN      = 7;
  localparam int GLB_VOL_FMT    = 6;
  localparam int GLB_WT_EN      = 3;
  localparam int FM_LVL_LSB     = 4;
  localparam int MONO_MUTE      = 7;
  localparam int DSP_FMT_LSB    = 2;
  localparam int DSP_EN         = 1;
  localparam int MONO_ATTEN     = 0;
  localparam int G2_CKSUM       = 4;
  localparam int G2_AUX_REMAP   = 3;
  localparam int G2_SPATIAL     = 2;
  localparam int G2_DSP_DAC1    = 1;
  localparam int G2_PB_HOLD     = 0;

  // Reset image, in image order (byte 5 .. byte 23)
  localparam logic [7:0] CFG_RESET [CFG_BYTES] = '{
    8'h00, 8'h03, 8'h80, 8'h80, 8'hE2, 8'h20, 8'h04, 8'h08, 8'h10, 8'h80,
    8'h00, 8'h00, 8'h04, 8'h48, 8'h75, 8'hB9, 8'hFC, 8'h10, 8'h03};

  typedef enum logic [2:0] {
    HCL_IDLE, HCL_ROM, HCL_ADDR_LO, HCL_ADDR_HI, HCL_DATA
  } hcl_state_type;

endpackage

// >>> rtl/hcl_loader.sv
`timescale 1ns/10ps
module hcl_loader
  import hcl_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire logic                    io_wr,
  input  wire logic [2:0]              io_ofs,
  input  wire logic [7:0]              io_wdata,
  input  wire logic [hcl_pkg::CFG_IDX_W-1:0] rd_idx,
  output logic      [7:0]              rd_data,
  output logic                         res_wr,
  output logic      [7:0]              res_data,
  output logic                         firmware_load_ok,
  output logic                         apply_pulse,
  output logic      [3:0]              alt_cd_bytes_log2,
  output logic                         alt_cd_len_valid,
  output logic                         hw_volume_enable,
  output logic                         second_key_block,
  output logic                         first_key_block,
  output logic                         pnp_key_block,
  output logic                         cd_irq_polarity_high,
  output logic                         wavetable_port_enable,
  output logic                         volume_button_format,
  output logic                         fm_synth_enable,
  output logic      [2:0]              fm_level_field,
  output logic                         fm_level_valid,
  output logic                         mono_in_atten,
  output logic                         mono_in_mute,
  output logic                         dsp_port_enable,
  output logic      [1:0]              dsp_port_format,
  output logic                         checksum_present,
  output logic      [7:0]              checksum_field,
  output logic                         playback_hold,
  output logic                         dsp_drives_dac_one,
  output logic                         spatial_sound_enable,
  output logic                         auxiliary_remap,
  output logic      [7:0]              cd_len_field,
  output logic                         cd_len_valid,
  output logic      [23:0]             irq_pin_map,
  output logic      [11:0]             dma_pin_map,
  output logic      [3:0]              irq_g_map,
  output logic                         irq_g_enable
);
  import hcl_pkg::*;

  typedef struct packed {
    hcl_state_type          st;
    logic [CFG_IDX_W-1:0]   idx;
    logic [CFG_BYTES*8-1:0] cfg;
    logic [7:0]             rd;
    logic                   res_wr;
    logic [7:0]             res_data;
    logic                   fw_ok;
    logic                   apply;
    logic [3:0]             alt_log2;
    logic                   alt_ok;
    logic [7:0]             misc;
    logic [7:0]             glb;
    logic [7:0]             fm;
    logic [7:0]             mono;
    logic [7:0]             g2;
    logic [7:0]             cks;
    logic [7:0]             cdl;
    logic [23:0]            irq;
    logic [15:0]            dma;
  } hcl_regs_type;

  hcl_regs_type cur_ff;
  hcl_regs_type nxt_ff;

  // Bits software may store in a byte; reserved positions read back zero
  function automatic logic [7:0] keep_mask(input logic [4:0] i);
    case (i)
      IDX_ALT_CD:   keep_mask = MASK_ALT_CD;
      IDX_GLOBAL:   keep_mask = MASK_GLOBAL;
      IDX_FM_LEVEL: keep_mask = MASK_FM_LEVEL;
      IDX_MONO_DSP: keep_mask = MASK_MONO_DSP;
      IDX_GLOBAL2:  keep_mask = MASK_GLOBAL2;
      default:      keep_mask = MASK_ALL;
    endcase
  endfunction

  function automatic logic [7:0] cfg_byte(input logic [CFG_BYTES*8-1:0] c,
                                          input logic [4:0] i);
    cfg_byte = c[i*8 +: 8];
  endfunction

  function automatic logic [CFG_BYTES*8-1:0] cfg_reset();
    for (int k = 0; k < CFG_BYTES; k++) begin
      cfg_reset[k*8 +: 8] = CFG_RESET[k] & keep_mask(5'(k));
    end
  endfunction

  logic cmd_wr;
  logic end_wr;

  always_comb begin
    logic [7:0] b;
    b      = 8'h00;
    nxt_ff = cur_ff;
    cmd_wr = io_wr && (io_ofs == LOADER_COMMAND_PORT_OFS);
    end_wr = io_wr && (io_ofs == DOWNLOAD_END_PORT_OFS);
    nxt_ff.res_wr = 1'b0;
    nxt_ff.apply  = 1'b0;
    nxt_ff.rd     = (rd_idx <= CFG_LAST) ? cfg_byte(cur_ff.cfg, rd_idx) : 8'h00;
    case (cur_ff.st)
      HCL_IDLE: begin
        if (cmd_wr && io_wdata == CMD_JUMP_ROM) begin
          nxt_ff.st = HCL_ROM;
        end else if (cmd_wr && io_wdata == CMD_REAPPLY) begin
          nxt_ff.apply = 1'b1;
        end
      end
      HCL_ROM: begin
        if (cmd_wr && io_wdata == CMD_DOWNLOAD) begin
          nxt_ff.st = HCL_ADDR_LO;
        end else if (cmd_wr && io_wdata == CMD_REAPPLY) begin
          nxt_ff.apply = 1'b1;
          nxt_ff.st    = HCL_IDLE;
        end
      end
      HCL_ADDR_LO: begin
        if (cmd_wr) begin
          nxt_ff.st = (io_wdata == START_ADDR_LO) ? HCL_ADDR_HI : HCL_IDLE;
        end
      end
      HCL_ADDR_HI: begin
        if (cmd_wr) begin
          nxt_ff.idx = '0;
          nxt_ff.st  = (io_wdata == START_ADDR_HI) ? HCL_DATA : HCL_IDLE;
        end
      end
      HCL_DATA: begin
        if (end_wr && io_wdata == CMD_END) begin
          nxt_ff.st = HCL_IDLE;
        end else if (cmd_wr) begin
          if (cur_ff.idx <= CFG_LAST) begin
            // First bytes land in the table, with no header expected
            nxt_ff.cfg[cur_ff.idx*8 +: 8] = io_wdata & keep_mask(cur_ff.idx);
            nxt_ff.idx = cur_ff.idx + 5'h01;
          end else begin
            nxt_ff.res_wr   = 1'b1;
            nxt_ff.res_data = io_wdata;
          end
        end
      end
      default: nxt_ff.st = HCL_IDLE;
    endcase

    // Decoded settings follow the table only when applied, so a partial
    // download never disturbs the live configuration
    if (cur_ff.apply) begin
      b = cfg_byte(cur_ff.cfg, IDX_ALT_CD);
      nxt_ff.alt_ok = 1'b1;
      case (b[2:0])
        3'h0:    nxt_ff.alt_log2 = 4'h0;
        3'h1:    nxt_ff.alt_log2 = 4'h1;
        3'h3:    nxt_ff.alt_log2 = 4'h2;
        3'h7:    nxt_ff.alt_log2 = 4'h3;
        default: begin
          nxt_ff.alt_log2 = 4'h0;
          nxt_ff.alt_ok   = 1'b0;
        end
      endcase
      nxt_ff.misc  = cfg_byte(cur_ff.cfg, IDX_MISC);
      nxt_ff.glb   = cfg_byte(cur_ff.cfg, IDX_GLOBAL);
      nxt_ff.fm    = cfg_byte(cur_ff.cfg, IDX_FM_LEVEL);
      nxt_ff.mono  = cfg_byte(cur_ff.cfg, IDX_MONO_DSP);
      nxt_ff.g2    = cfg_byte(cur_ff.cfg, IDX_GLOBAL2);
      nxt_ff.cks   = cfg_byte(cur_ff.cfg, IDX_CHECKSUM);
      nxt_ff.cdl   = cfg_byte(cur_ff.cfg, IDX_CD_LEN);
      nxt_ff.irq   = {cfg_byte(cur_ff.cfg, IDX_IRQ_EF), cfg_byte(cur_ff.cfg, IDX_IRQ_CD),
                      cfg_byte(cur_ff.cfg, IDX_IRQ_AB)};
      nxt_ff.dma   = {cfg_byte(cur_ff.cfg, IDX_DMA_C_IRQG),
                      cfg_byte(cur_ff.cfg, IDX_DMA_AB)};
      nxt_ff.fw_ok = (cfg_byte(cur_ff.cfg, IDX_CODE_BASE) == CODE_BASE_HOST);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff          <= '0;
      cur_ff.st       <= HCL_IDLE;
      cur_ff.cfg      <= cfg_reset();
      cur_ff.apply    <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs from the registers; a few enables and valid flags are decoded from them here
  always_comb begin
    rd_data               = cur_ff.rd;
    res_wr                = cur_ff.res_wr;
    res_data              = cur_ff.res_data;
    firmware_load_ok      = cur_ff.fw_ok;
    apply_pulse           = cur_ff.apply;
    alt_cd_bytes_log2     = cur_ff.alt_log2;
    alt_cd_len_valid      = cur_ff.alt_ok;
    hw_volume_enable      = cur_ff.misc[MISC_HW_VOL];
    second_key_block      = cur_ff.misc[MISC_SECOND_BLK];
    first_key_block       = cur_ff.misc[MISC_FIRST_BLK];
    pnp_key_block         = cur_ff.misc[MISC_PNP_BLK];
    cd_irq_polarity_high  = cur_ff.misc[MISC_IRQ_POL];
    // Wavetable pins need the DSP serial port off
    wavetable_port_enable = cur_ff.glb[GLB_WT_EN] & ~cur_ff.mono[DSP_EN];
    volume_button_format  = cur_ff.glb[GLB_VOL_FMT];
    fm_synth_enable       = cur_ff.glb[GLB_FM_EN];
    fm_level_field        = cur_ff.fm[FM_LVL_LSB +: 3];
    fm_level_valid        = cur_ff.fm[FM_LVL_LSB+1 +: 2] != 2'h0;
    mono_in_atten         = cur_ff.mono[MONO_ATTEN];
    mono_in_mute          = cur_ff.mono[MONO_MUTE];
    dsp_port_enable       = cur_ff.mono[DSP_EN];
    dsp_port_format       = cur_ff.mono[DSP_FMT_LSB +: 2];
    checksum_present      = cur_ff.g2[G2_CKSUM];
    checksum_field        = cur_ff.cks;
    playback_hold         = cur_ff.g2[G2_PB_HOLD];
    dsp_drives_dac_one    = cur_ff.g2[G2_DSP_DAC1];
    spatial_sound_enable  = cur_ff.g2[G2_SPATIAL];
    auxiliary_remap       = cur_ff.g2[G2_AUX_REMAP];
    cd_len_field          = cur_ff.cdl;
    cd_len_valid          = $onehot(cur_ff.cdl);
    irq_pin_map           = cur_ff.irq;
    dma_pin_map           = cur_ff.dma[11:0];
    irq_g_map             = cur_ff.dma[15:12];
    irq_g_enable          = cur_ff.dma[15:12] != 4'h0;
  end

  // Assertions
  reapply_update_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cur_ff.st == HCL_IDLE && cmd_wr && io_wdata == CMD_REAPPLY) |=> apply_pulse)
    else $error("reapply command did not pulse apply");
  jump_rom_seq_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cur_ff.st == HCL_IDLE && cmd_wr && io_wdata == CMD_JUMP_ROM) |=> cur_ff.st == HCL_ROM)
    else $error("jump command not taken");
  end_download_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cur_ff.st == HCL_DATA && end_wr && io_wdata == CMD_END) |=> cur_ff.st == HCL_IDLE)
    else $error("download end not taken");
  first_byte_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cur_ff.st == HCL_ADDR_HI && cmd_wr && io_wdata == START_ADDR_HI) |=>
    (cur_ff.idx == 5'h00 && cur_ff.st == HCL_DATA))
    else $error("image does not start at first table byte");
  wavetable_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    dsp_port_enable |-> !wavetable_port_enable)
    else $error("wavetable on while DSP port on");
  code_base_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    apply_pulse |=> firmware_load_ok == ($past(cur_ff.cfg[IDX_CODE_BASE*8 +: 8]) == CODE_BASE_HOST))
    else $error("code base check wrong");
  resource_after_cfg_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    res_wr |-> $past(cur_ff.idx) > CFG_LAST)
    else $error("resource byte before table full");
  reserved_drop_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cur_ff.cfg[IDX_ALT_CD*8+3 +: 5] == 5'h00) && (cur_ff.cfg[IDX_GLOBAL2*8+5 +: 3] == 3'h0))
    else $error("reserved bit stored");
  alt_mask_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (apply_pulse && cur_ff.cfg[IDX_ALT_CD*8 +: 3] == 3'h7) |=>
    (alt_cd_len_valid && alt_cd_bytes_log2 == 4'h3))
    else $error("alt mask decode broken");

endmodule // hcl_loader

// >>> verif/hcl_host_model.sv
`timescale 1ns/10ps
module hcl_host_model
  import hcl_pkg::*;
(
  input  wire logic       ref_clk,
  output logic            io_wr,
  output logic [2:0]      io_ofs,
  output logic [7:0]      io_wdata
);
  import hcl_pkg::*;

  initial begin
    io_wr    = 1'b0;
    io_ofs   = 3'h0;
    io_wdata = 8'h00;
  end

  // Caller sits just after a rising edge; the strobe stays up across back-to-back writes
  task automatic put(input logic [2:0] ofs, input logic [7:0] data);
    io_wr    <= 1'b1;
    io_ofs   <= ofs;
    io_wdata <= data;
    @(posedge ref_clk);
  endtask

  // Released data shows the inverse so a stale byte never passes for a fresh write
  task automatic idle();
    io_wr    <= 1'b0;
    io_wdata <= ~io_wdata;
    @(posedge ref_clk);
  endtask

  task automatic hostload(input logic [7:0] img [CFG_BYTES], input logic [7:0] r0,
                          input logic [7:0] r1);
    put(LOADER_COMMAND_PORT_OFS, CMD_JUMP_ROM);
    put(LOADER_COMMAND_PORT_OFS, CMD_DOWNLOAD);
    put(LOADER_COMMAND_PORT_OFS, START_ADDR_LO);
    put(LOADER_COMMAND_PORT_OFS, START_ADDR_HI);
    for (int k = 0; k < CFG_BYTES; k++) begin
      put(LOADER_COMMAND_PORT_OFS, img[k]);
    end
    put(LOADER_COMMAND_PORT_OFS, r0);
    put(LOADER_COMMAND_PORT_OFS, r1);
    put(DOWNLOAD_END_PORT_OFS, CMD_END);
  endtask

  task automatic reapply();
    put(LOADER_COMMAND_PORT_OFS, CMD_REAPPLY);
  endtask
endmodule // hcl_host_model

// >>> verif/hw_config_loader_bench.sv
`timescale 1ns/10ps
module hw_config_loader_bench;
  import hcl_pkg::*;
  logic        ref_clk, rstn, io_wr, res_wr, firmware_load_ok, apply_pulse;
  logic [2:0]  io_ofs, fm_level_field;
  logic [7:0]  io_wdata, rd_data, res_data, checksum_field, cd_len_field;
  logic [4:0]  rd_idx;
  logic [3:0]  alt_cd_bytes_log2, irq_g_map;
  logic [1:0]  dsp_port_format;
  logic [23:0] irq_pin_map;
  logic [11:0] dma_pin_map;
  logic        alt_cd_len_valid, hw_volume_enable, second_key_block, first_key_block;
  logic        pnp_key_block, cd_irq_polarity_high, wavetable_port_enable, volume_button_format;
  logic        fm_synth_enable, fm_level_valid, mono_in_atten, mono_in_mute, dsp_port_enable;
  logic        checksum_present, playback_hold, dsp_drives_dac_one, spatial_sound_enable;
  logic        auxiliary_remap, cd_len_valid, irq_g_enable;
  logic [7:0]  res_q [$];
  int          miscompares, n_compared, applies;
  logic [4:0]  ridx [8] = '{5'h00, 5'h02, 5'h03, 5'h05, 5'h09, 5'h0B, 5'h0C, 5'h13};
  wire logic [15:0] flags = {hw_volume_enable, second_key_block, first_key_block, pnp_key_block,
    cd_irq_polarity_high, wavetable_port_enable, volume_button_format, fm_synth_enable,
    mono_in_atten, mono_in_mute, dsp_port_enable, checksum_present, playback_hold,
    dsp_drives_dac_one, spatial_sound_enable, auxiliary_remap};

  hcl_loader dut (.ref_clk, .rstn, .io_wr, .io_ofs, .io_wdata, .rd_idx, .rd_data, .res_wr,
    .res_data, .firmware_load_ok, .apply_pulse, .alt_cd_bytes_log2, .alt_cd_len_valid,
    .hw_volume_enable, .second_key_block, .first_key_block, .pnp_key_block,
    .cd_irq_polarity_high, .wavetable_port_enable, .volume_button_format, .fm_synth_enable,
    .fm_level_field, .fm_level_valid, .mono_in_atten, .mono_in_mute, .dsp_port_enable,
    .dsp_port_format, .checksum_present, .checksum_field, .playback_hold, .dsp_drives_dac_one,
    .spatial_sound_enable, .auxiliary_remap, .cd_len_field, .cd_len_valid, .irq_pin_map,
    .dma_pin_map, .irq_g_map, .irq_g_enable);
  hcl_host_model host (.ref_clk, .io_wr, .io_ofs, .io_wdata);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Pulses are caught mid-cycle, away from the edge that launches them
  always @(negedge ref_clk) begin
    if (res_wr === 1'b1) res_q.push_back(res_data);
    if (apply_pulse === 1'b1) applies++;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Counts: compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic read_all(input logic [7:0] exp [8]);
    for (int k = 0; k < 8; k++) begin
      rd_idx <= ridx[k];
      @(posedge ref_clk);
      @(negedge ref_clk);
      check(rd_data, exp[k]);
      @(posedge ref_clk);
    end
  endtask

  // Decoded outputs must follow within two cycles of the command being taken
  task automatic apply_check();
    int n;
    n = applies;
    host.reapply();
    host.idle();
    @(negedge ref_clk);
    check(applies, n + 1);
    @(posedge ref_clk);
  endtask

  task automatic reset_defaults();
    check(flags, 16'h0940);
    check({fm_level_valid, fm_level_field, cd_len_valid, cd_len_field}, 13'h1504);
    check({alt_cd_len_valid, alt_cd_bytes_log2, firmware_load_ok}, 6'h21);
    check({irq_pin_map, dma_pin_map, irq_g_enable, irq_g_map}, 41'h1F972EA6200);
    read_all('{8'h00, 8'h80, 8'h80, 8'h20, 8'h80, 8'h00, 8'h04, 8'h00});
    $display("Test reset_defaults done");
  endtask

  task automatic full_hostload();
    res_q.delete();
    host.hostload('{8'hFB, 8'h03, 8'hFF, 8'hFF, 8'hE1, 8'hFF, 8'h04, 8'h08, 8'h10, 8'hFF,
      8'h5C, 8'hFF, 8'h80, 8'h48, 8'h12, 8'h34, 8'h56, 8'h98, 8'hA5}, 8'h3C, 8'hC3);
    apply_check();
    check(flags, 16'hFBFF);
    check({alt_cd_len_valid, alt_cd_bytes_log2, firmware_load_ok}, 6'h24);
    check({fm_level_valid, fm_level_field, dsp_port_format}, 6'h3F);
    check({cd_len_valid, cd_len_field, checksum_field}, 17'h1805C);
    check({irq_pin_map, dma_pin_map, irq_g_enable, irq_g_map}, 41'h0AC6824B31A);
    check({res_q.size(), res_q[0], res_q[1]}, {32'd2, 16'h3CC3});
    read_all('{8'h03, 8'hFF, 8'hEC, 8'h70, 8'h8F, 8'h1F, 8'h80, 8'h00});
    $display("Test full_hostload done");
  endtask

  task automatic field_codes();
    logic [7:0] img [CFG_BYTES];
    for (int i = 0; i < 8; i++) begin
      img = CFG_RESET;
      img[IDX_ALT_CD] = 8'(i);
      img[IDX_MISC] = 8'h00;
      img[IDX_GLOBAL] = 8'h08;
      img[IDX_FM_LEVEL] = 8'(i << 4);
      img[IDX_MONO_DSP] = 8'(((i & 3) << 2) | ((i & 1) << 1));
      img[IDX_CD_LEN] = (i == 7) ? 8'h81 : 8'(1 << i);
      host.hostload(img, 8'(i), 8'(~i));
      apply_check();
      check(alt_cd_len_valid, i == 0 || i == 1 || i == 3 || i == 7);
      if (alt_cd_len_valid === 1'b1) begin
        check(alt_cd_bytes_log2, $clog2(i + 1));
      end
      check({fm_level_valid, fm_level_field}, {i >= 2, 3'(i)});
      check({dsp_port_enable, dsp_port_format, wavetable_port_enable},
            {i % 2 == 1, 2'(i), i % 2 == 0});
      check({cd_len_valid, cd_len_field}, {i != 7, img[IDX_CD_LEN]});
      check({fm_synth_enable, volume_button_format, cd_irq_polarity_high, firmware_load_ok},
            4'h1);
    end
    $display("Test field_codes done");
  endtask

  // A broken download must leave the stored table alone
  task automatic refused_sequence();
    res_q.delete();
    host.put(LOADER_COMMAND_PORT_OFS, CMD_JUMP_ROM);
    host.put(LOADER_COMMAND_PORT_OFS, 8'h55);
    host.put(LOADER_COMMAND_PORT_OFS, START_ADDR_LO);
    host.put(LOADER_COMMAND_PORT_OFS, START_ADDR_HI);
    host.put(LOADER_COMMAND_PORT_OFS, 8'h01);
    host.put(DOWNLOAD_END_PORT_OFS, CMD_END);
    host.idle();
    apply_check();
    check({res_q.size(), alt_cd_len_valid, alt_cd_bytes_log2}, {32'd0, 5'h13});
    $display("Test refused_sequence done");
  endtask

  initial begin
    rstn = 1'b0;
    rd_idx = 5'h00;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset_defaults();
    full_hostload();
    field_codes();
    refused_sequence();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
endmodule // hw_config_loader_bench
